// ### rtl/stream_write_regs.svh
`ifndef STREAM_WRITE_REGS_SVH
`define STREAM_WRITE_REGS_SVH

// Register word offsets (byte addresses)
`define OFF_OPT_LOW 8'h00
`define OFF_OPT_HIGH 8'h04
`define OFF_COUNT 8'h08
`define OFF_LBA_LOW 8'h0c
`define OFF_LBA_HIGH 8'h10
`define OFF_CMD_STATUS 8'h14
`define OFF_ERR_LOG 8'h18
`define OFF_ERR_ADDR 8'h1c
`define OFF_CTRL 8'h20
`define OFF_TIME_UNIT 8'h24
`define OFF_SECT_LEFT 8'h28
`define OFF_DEFAULTS 8'h40

// Field positions
`define CTRL_UPPER_VIEW_BIT 0
`define DEFAULTS_IDX_MSB 4
`define DEFAULTS_IDX_LSB 2

// Command and counts
`define OPCODE_STREAM_WRITE 8'h3b
`define SECTORS_FOR_ZERO 17'h10000

// Reset values
`define RST_STATUS 8'h40
`define RST_ERR_LOG 8'h00
`define RST_TIME_UNIT 32'h0000_0001

// Timing
`define CLK_PERIOD_NS 8
`define MICROSECOND_NS 1000

`endif

// ### rtl/stream_write_pkg.sv
`default_nettype none
package stream_write_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_DRAIN = 3'b100
	} state_type;

	typedef struct packed {
		logic busy;
		logic ready;
		logic stream_fault_flag;
		logic fault_ds;
		logic drq;
		logic corrected;
		logic index;
		logic err;
	} status_type;

	typedef struct packed {
		logic crc;
		logic uncorrectable;
		logic rsv5;
		logic target_missing;
		logic rsv3;
		logic command_rejected;
		logic rsv1;
		logic deadline_expired_flag;
	} err_log_type;

	typedef struct packed {
		logic valid;
		logic target_missing;
		logic command_rejected;
	} media_fault_type;

	typedef struct packed {
		logic priority_request;
		logic write_continuous;
		logic flush;
		logic handle_error;
		logic rsv3;
		logic [2:0] stream_id;
	} opt_low_type;

endpackage
`default_nettype wire

// ### rtl/stream_write_cmd.sv
// How it works
// - Writing opcode 3Bh to the command register starts the streaming write.
// - Sector count of 1 to 65536 is moved; zero means 65536 sectors.
// - Option bit 6 sets write-continuous: errors never halt the command.
// - Write-continuous with errors: finish all sectors, then busy 0, fault 1, err 0.
// - That case logs target-missing or command-rejected in the error log.
// - Write-continuous deadline expiry stops the command: busy 0, fault 1, err 0.
// - Deadline expiry sets the deadline-expired flag in the error log.
// - Always try to move every requested sector before the deadline.
// - Option bit 7 marks priority; finish fast and within the deadline.
// - Deadline is high option byte times time unit, microseconds, from command write.
// - Zero byte uses stream default; zero default means none; below minimum is raised.
// - Low option bits carry stream id selecting per-stream behaviour.
// - Error completion returns first failing 48-bit address, upper view selects half.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "stream_write_regs.svh"

module stream_write_cmd #(
	parameter int DATA_W = 16,
	parameter int WORDS_PER_SECTOR = 256,
	parameter logic [39:0] MIN_DEADLINE_US = 40'h00_0000_0001
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Host data in
	input wire logic [DATA_W-1:0] host_data_in,
	input wire logic host_valid_in,
	output logic host_ready_out,
	// Media data out
	output logic [DATA_W-1:0] media_data_out,
	output logic media_valid_out,
	input wire logic media_ready_in,
	input wire stream_write_pkg::media_fault_type media_fault_in,
	// Command state
	output logic busy_out,
	output logic done_out,
	output logic priority_out,
	output logic [2:0] stream_id_out
);
	import stream_write_pkg::*;

	localparam int CYC_PER_US = `MICROSECOND_NS / `CLK_PERIOD_NS;
	localparam int WCNT_W = $clog2(WORDS_PER_SECTOR);

	opt_low_type opt_low_reg;
	logic [7:0] opt_high_reg;
	logic [15:0] count_reg;
	logic [47:0] lba_reg;
	logic upper_view_reg;
	logic [31:0] time_unit_reg;
	logic [31:0] default_reg [0:7];
	status_type status_reg;
	err_log_type err_log_reg;
	logic [47:0] err_addr_reg;
	logic err_seen_reg;
	state_type state_reg;
	logic [16:0] sect_left_reg;
	logic [WCNT_W-1:0] word_reg;
	logic [47:0] lba_cur_reg;
	logic wc_reg;
	logic [39:0] rem_us_reg;
	logic [6:0] presc_reg;
	logic dl_on_reg;
	logic [DATA_W-1:0] slot0_reg;
	logic [DATA_W-1:0] slot1_reg;
	logic [1:0] fill_reg;
	logic ack_reg;
	logic [31:0] rd_reg;

	logic wr_fire;
	logic start_cmd;
	logic bad_cmd;
	logic [31:0] rd_word;
	logic push;
	logic pop;
	logic last_word;
	logic expired;
	logic fault_stop;
	logic stop_now;
	logic drain_done;
	logic [1:0] fill_next;
	logic [1:0] occ;
	logic [39:0] dl_load;
	logic [39:0] dl_raw;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Bus slave: one wait state, write lands on the edge that sees ack
	assign wr_fire = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;
	assign start_cmd = wr_fire && (wb_adr_in == `OFF_CMD_STATUS) && wb_sel_in[0] &&
		!status_reg.busy && (wb_dat_in[7:0] == `OPCODE_STREAM_WRITE);
	assign bad_cmd = wr_fire && (wb_adr_in == `OFF_CMD_STATUS) && wb_sel_in[0] &&
		!status_reg.busy && (wb_dat_in[7:0] != `OPCODE_STREAM_WRITE);

	always_comb begin
		rd_word = 32'h0000_0000;
		if (wb_adr_in == `OFF_CMD_STATUS) begin
			rd_word = {24'h00_0000, status_reg};
		end else if (wb_adr_in == `OFF_ERR_LOG) begin
			rd_word = {24'h00_0000, err_log_reg};
		end else if (wb_adr_in == `OFF_ERR_ADDR) begin
			rd_word = {8'h00, upper_view_reg ? err_addr_reg[47:24] : err_addr_reg[23:0]};
		end else if (wb_adr_in == `OFF_CTRL) begin
			rd_word = {31'h0000_0000, upper_view_reg};
		end else if (wb_adr_in == `OFF_TIME_UNIT) begin
			rd_word = time_unit_reg;
		end else if (wb_adr_in == `OFF_SECT_LEFT) begin
			rd_word = {15'h0000, sect_left_reg};
		end else if (wb_adr_in[7:5] == 3'h2) begin
			rd_word = default_reg[wb_adr_in[`DEFAULTS_IDX_MSB:`DEFAULTS_IDX_LSB]];
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
			if (wb_cyc_in && wb_stb_in && !ack_reg) begin
				rd_reg <= rd_word;
			end
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rd_reg;

	// Command block; an option, count or LBA write while busy is dropped so a running command stays intact
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			opt_low_reg <= '0;
			opt_high_reg <= 8'h00;
			count_reg <= 16'h0000;
			lba_reg <= 48'h0000_0000_0000;
			upper_view_reg <= 1'b0;
			time_unit_reg <= `RST_TIME_UNIT;
			for (int i = 0; i < 8; i++) begin
				default_reg[i] <= 32'h0000_0000;
			end
		end else if (wr_fire) begin
			if (wb_adr_in == `OFF_CTRL && wb_sel_in[0]) begin
				upper_view_reg <= wb_dat_in[`CTRL_UPPER_VIEW_BIT];
			end else if (wb_adr_in == `OFF_TIME_UNIT) begin
				time_unit_reg <= merge(time_unit_reg, wb_dat_in, wb_sel_in);
			end else if (wb_adr_in[7:5] == 3'h2) begin
				default_reg[wb_adr_in[`DEFAULTS_IDX_MSB:`DEFAULTS_IDX_LSB]] <=
					merge(default_reg[wb_adr_in[`DEFAULTS_IDX_MSB:`DEFAULTS_IDX_LSB]],
					wb_dat_in, wb_sel_in);
			end else if (!status_reg.busy) begin
				if (wb_adr_in == `OFF_OPT_LOW && wb_sel_in[0]) begin
					opt_low_reg <= wb_dat_in[7:0];
				end else if (wb_adr_in == `OFF_OPT_HIGH && wb_sel_in[0]) begin
					opt_high_reg <= wb_dat_in[7:0];
				end else if (wb_adr_in == `OFF_COUNT) begin
					count_reg <= 16'(merge({16'h0000, count_reg}, wb_dat_in, wb_sel_in));
				end else if (wb_adr_in == `OFF_LBA_LOW) begin
					lba_reg[23:0] <= 24'(merge({8'h00, lba_reg[23:0]}, wb_dat_in, wb_sel_in));
				end else if (wb_adr_in == `OFF_LBA_HIGH) begin
					lba_reg[47:24] <= 24'(merge({8'h00, lba_reg[47:24]}, wb_dat_in, wb_sel_in));
				end
			end
		end
	end

	// Deadline in microseconds
	always_comb begin
		dl_raw = 40'(opt_high_reg) * 40'(time_unit_reg);
		if (opt_high_reg == 8'h00) begin
			dl_raw = 40'(default_reg[opt_low_reg.stream_id]);
		end
		dl_load = (dl_raw < MIN_DEADLINE_US) ? MIN_DEADLINE_US : dl_raw;
	end

	// Counting starts at the command write and stops at completion
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dl_on_reg <= 1'b0;
			rem_us_reg <= 40'h00_0000_0000;
			presc_reg <= 7'h00;
		end else if (start_cmd) begin
			dl_on_reg <= (dl_raw != 40'h00_0000_0000);
			rem_us_reg <= dl_load;
			presc_reg <= 7'h00;
		end else if (state_reg == ST_IDLE) begin
			dl_on_reg <= 1'b0;
		end else if (presc_reg == 7'(CYC_PER_US - 1)) begin
			presc_reg <= 7'h00;
			if (rem_us_reg != 40'h00_0000_0000) begin
				rem_us_reg <= rem_us_reg - 40'h00_0000_0001;
			end
		end else begin
			presc_reg <= presc_reg + 7'h01;
		end
	end

	assign expired = dl_on_reg && (rem_us_reg == 40'h00_0000_0000) && (state_reg != ST_IDLE);
	assign fault_stop = media_fault_in.valid && !wc_reg && (state_reg != ST_IDLE);
	assign stop_now = expired || fault_stop;
	assign last_word = (word_reg == WCNT_W'(WORDS_PER_SECTOR - 1)) &&
		(sect_left_reg == 17'h0_0001);
	assign drain_done = (state_reg == ST_DRAIN) && (fill_reg == 2'h0);

	// Two-entry buffer keeps words safe while the media side stalls
	assign pop = media_valid_out && media_ready_in;
	assign push = host_valid_in && host_ready_out && (state_reg == ST_XFER) && !stop_now;
	assign occ = fill_reg - {1'b0, pop};
	assign fill_next = stop_now ? 2'h0 : occ + {1'b0, push};

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fill_reg <= 2'h0;
			slot0_reg <= '0;
			slot1_reg <= '0;
			media_valid_out <= 1'b0;
			host_ready_out <= 1'b0;
		end else begin
			fill_reg <= fill_next;
			if (pop && fill_reg == 2'h2) begin
				slot0_reg <= slot1_reg;
			end
			if (push && occ == 2'h0) begin
				slot0_reg <= host_data_in;
			end else if (push) begin
				slot1_reg <= host_data_in;
			end
			media_valid_out <= (fill_next != 2'h0);
			host_ready_out <= (fill_next != 2'h2) && (state_reg == ST_XFER) &&
				!stop_now && !(push && last_word);
		end
	end

	assign media_data_out = slot0_reg;

	// Sequencing: sectors, errors and completion status
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_IDLE;
			status_reg <= `RST_STATUS;
			err_log_reg <= `RST_ERR_LOG;
			err_addr_reg <= 48'h0000_0000_0000;
			err_seen_reg <= 1'b0;
			sect_left_reg <= 17'h0_0000;
			word_reg <= '0;
			lba_cur_reg <= 48'h0000_0000_0000;
			wc_reg <= 1'b0;
			done_out <= 1'b0;
			busy_out <= 1'b0;
			priority_out <= 1'b0;
			stream_id_out <= 3'h0;
		end else begin
			done_out <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start_cmd) begin
						state_reg <= ST_XFER;
						status_reg <= `RST_STATUS;
						status_reg.busy <= 1'b1;
						status_reg.drq <= 1'b1;
						err_log_reg <= `RST_ERR_LOG;
						err_seen_reg <= 1'b0;
						sect_left_reg <= (count_reg == 16'h0000) ?
							`SECTORS_FOR_ZERO : {1'b0, count_reg};
						word_reg <= '0;
						lba_cur_reg <= lba_reg;
						wc_reg <= opt_low_reg.write_continuous;
						busy_out <= 1'b1;
						priority_out <= opt_low_reg.priority_request;
						stream_id_out <= opt_low_reg.stream_id;
					end else if (bad_cmd) begin
						status_reg.err <= 1'b1;
						err_log_reg <= `RST_ERR_LOG;
						err_log_reg.command_rejected <= 1'b1;
						done_out <= 1'b1;
					end
				end
				ST_XFER, ST_DRAIN: begin
					if (media_fault_in.valid) begin
						err_log_reg.target_missing <= err_log_reg.target_missing ||
							media_fault_in.target_missing;
						err_log_reg.command_rejected <= err_log_reg.command_rejected ||
							media_fault_in.command_rejected;
						err_seen_reg <= 1'b1;
						if (!err_seen_reg) begin
							err_addr_reg <= lba_cur_reg;
						end
					end
					if (stop_now || drain_done) begin
						state_reg <= ST_IDLE;
						status_reg.busy <= 1'b0;
						status_reg.drq <= 1'b0;
						busy_out <= 1'b0;
						done_out <= 1'b1;
						status_reg.stream_fault_flag <= wc_reg &&
							(expired || err_seen_reg || media_fault_in.valid);
						status_reg.err <= !wc_reg &&
							(expired || media_fault_in.valid);
						if (expired) begin
							err_log_reg.deadline_expired_flag <= 1'b1;
						end
					end else if (push) begin
						// With write-continuous set, a bad word does not end the sector walk
						word_reg <= word_reg + WCNT_W'(1);
						if (word_reg == WCNT_W'(WORDS_PER_SECTOR - 1)) begin
							word_reg <= '0;
							sect_left_reg <= sect_left_reg - 17'h0_0001;
							lba_cur_reg <= lba_cur_reg + 48'h0000_0000_0001;
							if (last_word) begin
								state_reg <= ST_DRAIN;
								status_reg.drq <= 1'b0;
							end
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### test/stream_write_cmd_chk.sv
`timescale 1ns/10ps
`default_nettype none
module stream_write_cmd_chk #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Register bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_ack_out,
	// Data path
	input wire logic host_ready_out,
	input wire logic [DATA_W-1:0] media_data_out,
	input wire logic media_valid_out,
	input wire logic media_ready_in,
	// Command state
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic priority_out,
	input wire logic [2:0] stream_id_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	logic cmd_wr;
	// Only an idle command write may start anything
	assign cmd_wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0] &&
		wb_adr_in == 8'h14 && !busy_out;
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
	ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack late");
	start_cmd_a: assert property (cmd_wr && wb_dat_in[7:0] == 8'h3b |=> busy_out)
		else $error("no start");
	bad_opcode_a: assert property (cmd_wr && wb_dat_in[7:0] != 8'h3b |=>
		!busy_out && done_out) else $error("bad opcode handling");
	done_pulse_a: assert property (done_out |=> !done_out) else $error("done too long");
	idle_refuse_a: assert property (!busy_out |-> !host_ready_out) else $error("ready while idle");
	// A stopped command flushes the buffer, so a held word may vanish only as busy drops
	media_hold_a: assert property (media_valid_out && !media_ready_in |=>
		!busy_out || (media_valid_out && $stable(media_data_out))) else $error("media word lost");
	stream_id_stable_a: assert property (busy_out && $past(busy_out) |->
		$stable({priority_out, stream_id_out})) else $error("stream id moved");
endmodule
bind stream_write_cmd stream_write_cmd_chk #(.DATA_W(DATA_W)) chk_i (.clock_in, .arst_n_in,
	.wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out,
	.host_ready_out,
	.media_data_out, .media_valid_out, .media_ready_in, .busy_out, .done_out, .priority_out,
	.stream_id_out);
`default_nettype wire

// ### test/media_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
module media_sink_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Bench control
	input wire logic stall_en_in,
	input wire logic [1:0] fault_kind_in,
	// Media side
	output logic media_ready_out,
	output var stream_write_pkg::media_fault_type media_fault_out
);
	import stream_write_pkg::*;
	logic [7:0] lfsr_reg;
	// Pseudo-random stalls keep the two-entry buffer filling and draining
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lfsr_reg <= 8'h5a;
			media_ready_out <= 1'b0;
			media_fault_out <= '0;
		end else begin
			lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
			media_ready_out <= !stall_en_in || lfsr_reg[0];
			media_fault_out <= {|fault_kind_in, fault_kind_in};
		end
	end
endmodule
`default_nettype wire

// ### test/stream_write_command_handler_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module stream_write_command_handler_tb_top;
	localparam int WPS = 2;
	logic clock_in = 0, arst_n_in = 0, cyc = 0, stb = 0, we = 0, hv = 1, mrdy, hrdy, mval;
	logic ack, busy, done, pri;
	logic [2:0] sid;
	logic [31:0] lba = 0;
	logic [1:0] fk = 0;
	logic [7:0] adr = 0;
	logic [15:0] hdat = 0, mdat;
	logic [31:0] wdat = 0, rdat, wb_q, s = 28;
	stream_write_pkg::media_fault_type mf;
	logic [15:0] sent[$], got[$];
	int num_errors = 0, n_checks = 0;
	always #4 clock_in = ~clock_in;
	stream_write_cmd #(.WORDS_PER_SECTOR(WPS)) dut (.clock_in, .arst_n_in, .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
		.wb_dat_out(wb_q), .wb_ack_out(ack), .host_data_in(hdat), .host_valid_in(hv),
		.host_ready_out(hrdy), .media_data_out(mdat), .media_valid_out(mval), .media_ready_in(mrdy),
		.media_fault_in(mf), .busy_out(busy), .done_out(done), .priority_out(pri),
		.stream_id_out(sid));
	media_sink_model sink (.clock_in, .arst_n_in, .stall_en_in(1'b1), .fault_kind_in(fk),
		.media_ready_out(mrdy), .media_fault_out(mf));
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [31:0] exp_words(input logic [15:0] cnt);
		return (cnt == 0 ? 32'h10000 : 32'(cnt)) * WPS;
	endfunction
	always @(posedge clock_in) begin
		if (hv && hrdy) begin
			sent.push_back(hdat);
			hdat <= 16'(rnd());
		end
		if (mval && mrdy) got.push_back(mdat);
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = wb_q;
		chk(n < 20, 1);
		cyc <= 0;
		stb <= 0;
		@(posedge clock_in);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(0, a, 0);
		chk(rdat, e);
	endtask
	task go(input logic [7:0] ol, input logic [7:0] oh, input logic [15:0] cnt, input logic [1:0] k);
		int n;
		sent.delete();
		got.delete();
		wb(1, 8'h00, {24'h0, ol});
		wb(1, 8'h04, {24'h0, oh});
		wb(1, 8'h08, {16'h0, cnt});
		lba = rnd() & 32'h00ff_ffff;
		wb(1, 8'h0c, lba);
		wb(1, 8'h10, 0);
		wb(1, 8'h14, 32'h3b);
		// Fault pulse lands while the first sector is still being received
		fk <= k;
		@(posedge clock_in);
		fk <= 0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clock_in);
			n++;
		end
		chk(n < 3000, 1);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock_in);
		arst_n_in <= 1;
		rd(8'h14, 32'h40);
		rd(8'h18, 0);
		rd(8'h24, 1);
		rd(8'h30, 0);
		wb(1, 8'h14, 32'h20);
		rd(8'h14, 32'h41);
		rd(8'h18, 32'h04);
		go(8'h85, 0, 3, 0);
		chk(32'(got.size()), exp_words(3));
		foreach (got[i]) chk({16'h0, got[i]}, {16'h0, sent[i]});
		rd(8'h14, 32'h40);
		chk(32'(pri), 1);
		chk(32'(sid), 5);
		rd(8'h28, 0);
		for (int k = 1; k < 3; k++) begin
			go(8'h40, 0, 2, 2'(k));
			chk(32'(got.size()), exp_words(2));
			rd(8'h14, 32'h60);
			rd(8'h18, k[1] ? 32'h10 : 32'h04);
		end
		go(8'h00, 0, 4, 2'b01);
		rd(8'h14, 32'h41);
		rd(8'h1c, lba);
		wb(1, 8'h20, 1);
		rd(8'h1c, 0);
		wb(1, 8'h20, 0);
		go(8'h40, 8'h01, 0, 0);
		rd(8'h14, 32'h60);
		rd(8'h18, 32'h01);
		give_verdict;
	end
	initial begin
		#(50000 * 8);
		num_errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
